//--- isoe_regs.svh
// Purpose: constants for the increment-skip and OR execute block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   included by the package and the execute modules
//
// What this block does
// - Decode increment-skip-nonzero opcode, flags untouched.
// - Destination bit 0 to working register, 1 to file.
// - Nonzero increment result cancels fetched next instruction.
// - Increment-skip takes one cycle, two when skipping.
// - Decode OR-literal opcode, one word, one cycle.
// - OR literal into working register, update zero.
// - Decode OR-register opcode, destination, zero, one cycle.
`ifndef ISOE_REGS_SVH
`define ISOE_REGS_SVH

`define ISOE_INC_OPC    7'h12
`define ISOE_ORR_OPC    7'h04
`define ISOE_ORL_OPC    8'hb3
`define ISOE_OPC7_POS   9
`define ISOE_OPC8_POS   8
`define ISOE_DBIT_POS   8
`define ISOE_WORKING_REGISTER_RST   8'h00
`define ISOE_ZERO_RST   1'h0
`define ISOE_PHASES     4

`endif

//--- isoe_pkg.sv
// Purpose: types shared by the execute block and its arithmetic unit
// Assumes: isoe_regs.svh holds the opcode constants
// Notes:   opcode decode lives here so both files see one definition
`include "isoe_regs.svh"
package isoe_pkg;

  typedef logic [15:0] isoe_word_t;
  typedef logic [7:0]  isoe_byte_t;

  typedef enum logic [3:0] {
    ISOE_Q1 = 4'h1,
    ISOE_Q2 = 4'h2,
    ISOE_Q3 = 4'h4,
    ISOE_Q4 = 4'h8
  } isoe_phase_t;

  typedef enum logic [4:0] {
    ISOE_OP_OTHER = 5'h01,
    ISOE_OP_NOP   = 5'h02,
    ISOE_OP_INC   = 5'h04,
    ISOE_OP_ORL   = 5'h08,
    ISOE_OP_ORR   = 5'h10
  } isoe_op_t;

  typedef struct packed {
    logic       en;
    isoe_byte_t addr;
    isoe_byte_t data;
  } isoe_wr_t;

  typedef struct packed {
    logic z_we;
    logic z;
  } isoe_stat_t;

  function automatic isoe_op_t isoe_decode(input isoe_word_t w);
    isoe_op_t op;
    op = ISOE_OP_OTHER;
    if (w[15:`ISOE_OPC7_POS] == `ISOE_INC_OPC) begin
      op = ISOE_OP_INC;
    end else if (w[15:`ISOE_OPC7_POS] == `ISOE_ORR_OPC) begin
      op = ISOE_OP_ORR;
    end else if (w[15:`ISOE_OPC8_POS] == `ISOE_ORL_OPC) begin
      op = ISOE_OP_ORL;
    end
    return op;
  endfunction

endpackage

//--- isoe_alu.sv
// Purpose: result, zero and skip terms for the three executed operations
// Assumes: operands are stable during the execute phase
// Notes:   purely combinational; the caller registers every output
`timescale 1ns/10ps
module isoe_alu
  import isoe_pkg::*;
(
  input  var isoe_op_t   op,
  input  wire isoe_byte_t lit,
  input  wire isoe_byte_t working_register,
  input  wire isoe_byte_t fdata,
  output isoe_byte_t      result,
  output logic            zero,
  output logic            skip
);

  always_comb begin
    result = 8'h00;
    skip   = 1'b0;
    case (op)
      ISOE_OP_INC: begin
        result = 8'(fdata + 8'h01);
        skip   = (result != 8'h00);
      end
      ISOE_OP_ORL: begin
        result = working_register | lit;
      end
      ISOE_OP_ORR: begin
        result = working_register | fdata;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule

//--- isoe_exec.sv
// Purpose: four-phase decode and execute of increment-skip and OR ops
// Assumes: instr is stable at the edge ending phase 1; rd_data is
//          valid at the edge ending phase 3 for the address on rd_addr
// Notes:   other opcodes pass as no-ops here; the rest of the core
//          executes them
`timescale 1ns/10ps
`include "isoe_regs.svh"
module isoe_exec
  import isoe_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire isoe_word_t instr,
  input  wire isoe_byte_t rd_data,
  output isoe_phase_t     phase,
  output isoe_byte_t      rd_addr,
  output isoe_wr_t        wr,
  output isoe_byte_t      working_register,
  output isoe_stat_t      stat,
  output logic            skip,
  output logic            forced_nop
);

  isoe_phase_t phase_r,   phase_nxt;
  isoe_op_t    op_r,      op_nxt;
  isoe_byte_t  lit_r,     lit_nxt;
  logic        dbit_r,    dbit_nxt;
  isoe_byte_t  rd_addr_r, rd_addr_nxt;
  isoe_wr_t    wr_r,      wr_nxt;
  isoe_byte_t  working_register_r,    working_register_nxt;
  isoe_stat_t  stat_r,    stat_nxt;
  logic        skip_r,    skip_nxt;
  logic        fnop_r,    fnop_nxt;

  isoe_byte_t alu_res;
  logic       alu_zero;
  logic       alu_skip;

  isoe_alu u_alu (
    .op     (op_r),
    .lit    (lit_r),
    .working_register   (working_register_r),
    .fdata  (rd_data),
    .result (alu_res),
    .zero   (alu_zero),
    .skip   (alu_skip)
  );

  always_comb begin
    phase_nxt   = phase_r;
    op_nxt      = op_r;
    lit_nxt     = lit_r;
    dbit_nxt    = dbit_r;
    rd_addr_nxt = rd_addr_r;
    working_register_nxt    = working_register_r;
    skip_nxt    = skip_r;
    fnop_nxt    = fnop_r;
    // Write and flag strobes last one clock, inside phase 4 only
    wr_nxt      = '{en: 1'b0, addr: wr_r.addr, data: wr_r.data};
    stat_nxt    = '{z_we: 1'b0, z: stat_r.z};
    case (phase_r)
      ISOE_Q1: begin
        phase_nxt = ISOE_Q2;
        if (skip_r) begin
          // Fetched word is dropped; a no-op fills its slot
          op_nxt   = ISOE_OP_NOP;
          fnop_nxt = 1'b1;
          skip_nxt = 1'b0;
        end else begin
          op_nxt      = isoe_decode(instr);
          lit_nxt     = instr[7:0];
          dbit_nxt    = instr[`ISOE_DBIT_POS];
          rd_addr_nxt = instr[7:0];
          fnop_nxt    = 1'b0;
        end
      end
      ISOE_Q2: begin
        phase_nxt = ISOE_Q3;
      end
      ISOE_Q3: begin
        phase_nxt = ISOE_Q4;
        case (op_r)
          ISOE_OP_INC: begin
            // Status flags deliberately left alone
            if (dbit_r) begin
              wr_nxt = '{en: 1'b1, addr: lit_r, data: alu_res};
            end else begin
              working_register_nxt = alu_res;
            end
            skip_nxt = alu_skip;
          end
          ISOE_OP_ORL: begin
            working_register_nxt = alu_res;
            stat_nxt = '{z_we: 1'b1, z: alu_zero};
          end
          ISOE_OP_ORR: begin
            if (dbit_r) begin
              wr_nxt = '{en: 1'b1, addr: lit_r, data: alu_res};
            end else begin
              working_register_nxt = alu_res;
            end
            stat_nxt = '{z_we: 1'b1, z: alu_zero};
          end
          default: begin
            working_register_nxt = working_register_r;
          end
        endcase
      end
      ISOE_Q4: begin
        phase_nxt = ISOE_Q1;
      end
      default: begin
        // Illegal phase code recovers to a clean cycle start
        phase_nxt = ISOE_Q1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_r   <= ISOE_Q1;
      op_r      <= ISOE_OP_NOP;
      lit_r     <= 8'h00;
      dbit_r    <= 1'b0;
      rd_addr_r <= 8'h00;
      wr_r      <= '{en: 1'b0, addr: 8'h00, data: 8'h00};
      working_register_r    <= `ISOE_WORKING_REGISTER_RST;
      stat_r    <= '{z_we: 1'b0, z: `ISOE_ZERO_RST};
      skip_r    <= 1'b0;
      fnop_r    <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      op_r      <= op_nxt;
      lit_r     <= lit_nxt;
      dbit_r    <= dbit_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_r      <= wr_nxt;
      working_register_r    <= working_register_nxt;
      stat_r    <= stat_nxt;
      skip_r    <= skip_nxt;
      fnop_r    <= fnop_nxt;
    end
  end

  assign phase      = phase_r;
  assign rd_addr    = rd_addr_r;
  assign wr         = wr_r;
  assign working_register       = working_register_r;
  assign stat       = stat_r;
  assign skip       = skip_r;
  assign forced_nop = fnop_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence exec_inc_s;
    phase_r == ISOE_Q3 && op_r == ISOE_OP_INC;
  endsequence

  sequence exec_orl_s;
    phase_r == ISOE_Q3 && op_r == ISOE_OP_ORL;
  endsequence

  sequence exec_orr_s;
    phase_r == ISOE_Q3 && op_r == ISOE_OP_ORR;
  endsequence

  sequence nop_slot_s;
    fnop_r && op_r == ISOE_OP_NOP ##2 (!wr_r.en && !stat_r.z_we);
  endsequence

  phase_ring_a: assert property (
    phase_r == ISOE_Q1 |=> phase_r == ISOE_Q2 ##1 phase_r == ISOE_Q3
      ##1 phase_r == ISOE_Q4 ##1 phase_r == ISOE_Q1)
    else $error("phase sequence broken");

  inc_decode_a: assert property (
    phase_r == ISOE_Q1 && !skip_r
      && instr[15:`ISOE_OPC7_POS] == `ISOE_INC_OPC |=> op_r == ISOE_OP_INC)
    else $error("increment opcode not decoded");

  inc_file_a: assert property (
    exec_inc_s and dbit_r |=> wr_r.en && wr_r.addr == $past(lit_r)
      && wr_r.data == 8'($past(rd_data) + 8'h01) && working_register_r == $past(working_register_r))
    else $error("increment to file wrong");

  inc_working_register_a: assert property (
    exec_inc_s and !dbit_r |=> !wr_r.en
      && working_register_r == 8'($past(rd_data) + 8'h01))
    else $error("increment to working register wrong");

  inc_noflag_a: assert property (
    exec_inc_s |=> !stat_r.z_we && $stable(stat_r.z))
    else $error("increment touched zero flag");

  skip_taken_a: assert property (
    exec_inc_s and rd_data != 8'hff |=> skip_r ##2 nop_slot_s)
    else $error("nonzero increment did not skip");

  skip_none_a: assert property (
    exec_inc_s and rd_data == 8'hff |=> !skip_r ##2 !fnop_r)
    else $error("zero increment skipped");

  skip_cycles_a: assert property (
    skip_r && phase_r == ISOE_Q1 |=> nop_slot_s ##2 !skip_r)
    else $error("skip cycle not a single forced no-op");

  orl_decode_a: assert property (
    phase_r == ISOE_Q1 && !skip_r
      && instr[15:`ISOE_OPC8_POS] == `ISOE_ORL_OPC |=> op_r == ISOE_OP_ORL)
    else $error("or-literal opcode not decoded");

  orl_result_a: assert property (
    exec_orl_s |=> working_register_r == ($past(working_register_r) | $past(lit_r)) && !wr_r.en
      && stat_r.z_we)
    else $error("or-literal result wrong");

  orr_dest_a: assert property (
    exec_orr_s |=> stat_r.z_we && (dbit_r ? (wr_r.en
      && wr_r.data == ($past(working_register_r) | $past(rd_data)))
      : (working_register_r == ($past(working_register_r) | $past(rd_data)) && !wr_r.en)))
    else $error("or-register result wrong");

  zero_flag_a: assert property (
    stat_r.z_we |-> stat_r.z == ((wr_r.en ? wr_r.data : working_register_r) == 8'h00))
    else $error("zero flag disagrees with result");

endmodule

//--- isoe_exec_tb_top.sv
// Purpose: self-checking bench for the increment-skip and OR execute block
// Assumes: one instruction every four clocks, inputs moved 10 ns after edge
// Notes:   every scenario starts and ends with the block in phase Q1
`timescale 1ns/10ps
module isoe_exec_tb_top
  import isoe_pkg::*;
;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  isoe_word_t  instr = 16'h0000;
  isoe_byte_t  rd_data = 8'h00;
  isoe_phase_t phase;
  isoe_byte_t  rd_addr;
  isoe_wr_t    wr;
  isoe_byte_t  working_register;
  isoe_stat_t  stat;
  logic        skip;
  logic        forced_nop;
  int          n_errors = 0;
  int          n_tests = 0;

  isoe_exec u_dut (
    .clock      (clock),
    .nrst       (nrst),
    .instr      (instr),
    .rd_data    (rd_data),
    .phase      (phase),
    .rd_addr    (rd_addr),
    .wr         (wr),
    .working_register       (working_register),
    .stat       (stat),
    .skip       (skip),
    .forced_nop (forced_nop)
  );

  always #50 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("tests %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #10;
    end
  endtask

  // Presents a word in Q1 and returns in Q4 of the same cycle
  task automatic issue(input isoe_word_t w, input isoe_byte_t d);
    check(phase, ISOE_Q1);
    instr = w;
    rd_data = d;
    step(3);
  endtask

  // Word fetched behind a skipping increment must leave no trace
  task automatic discard(input isoe_word_t w, input isoe_byte_t wexp);
    step(1);
    instr = w;
    rd_data = 8'h5a;
    check(skip, 1'b1);
    step(1);
    check(forced_nop, 1'b1);
    check(skip, 1'b0);
    step(2);
    check(wr.en, 1'b0);
    check(stat.z_we, 1'b0);
    check(working_register, wexp);
    step(1);
    check(forced_nop, 1'b1);
  endtask

  task automatic t_orl_zero();
    issue(16'hb300, 8'h00);
    check(working_register, 8'h00);
    check(stat, 2'b11);
    check(wr.en, 1'b0);
    step(1);
    check(stat.z_we, 1'b0);
    $display("test orl_zero done");
  endtask

  task automatic t_inc_skip();
    issue(16'h2510, 8'h07);
    check(wr, {1'b1, 8'h10, 8'h08});
    check(working_register, 8'h00);
    check(stat, 2'b01);
    check(skip, 1'b1);
    discard(16'hb3ff, 8'h00);
    $display("test inc_skip done");
  endtask

  task automatic t_inc_wrap();
    issue(16'h2511, 8'hff);
    check(wr, {1'b1, 8'h11, 8'h00});
    check(skip, 1'b0);
    check(forced_nop, 1'b0);
    check(stat, 2'b01);
    step(1);
    issue(16'hb301, 8'h00);
    check(working_register, 8'h01);
    check(stat, 2'b10);
    step(1);
    $display("test inc_wrap done");
  endtask

  task automatic t_orl();
    issue(16'hb39a, 8'h00);
    check(working_register, 8'h9b);
    step(1);
    issue(16'hb335, 8'h00);
    check(working_register, 8'hbf);
    check(stat, 2'b10);
    check(wr.en, 1'b0);
    step(1);
    $display("test orl done");
  endtask

  task automatic t_inc_working_register();
    issue(16'h2420, 8'h90);
    check(working_register, 8'h91);
    check(wr.en, 1'b0);
    check(skip, 1'b1);
    discard(16'h0920, 8'h91);
    $display("test inc_working_register done");
  endtask

  task automatic t_orr();
    issue(16'h0813, 8'h13);
    check(working_register, 8'h93);
    check(rd_addr, 8'h13);
    check(wr.en, 1'b0);
    check(stat, 2'b10);
    step(1);
    issue(16'h0920, 8'h0c);
    check(wr, {1'b1, 8'h20, 8'h9f});
    check(working_register, 8'h93);
    step(1);
    $display("test orr done");
  endtask

  task automatic t_other();
    isoe_word_t w [3] = '{16'h2620, 16'hb400, 16'h0a00};
    foreach (w[i]) begin
      issue(w[i], 8'h00);
      check({wr.en, stat.z_we, skip}, 3'h0);
      check(working_register, 8'h93);
      step(1);
    end
    $display("test other done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #10;
    check(phase, ISOE_Q1);
    check({rd_addr, wr}, 25'h0000000);
    check({working_register, stat, skip, forced_nop}, 12'h000);
    nrst = 1'b1;
    t_orl_zero();
    t_inc_skip();
    t_inc_wrap();
    t_orl();
    t_inc_working_register();
    t_orr();
    t_other();
    close_out();
  end

  // Whole run needs about 76 clocks; allow a wide margin
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
